// >>> core/fci_ctrl.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ns
`include "fci_defs.svh"
module fci_ctrl #(
	parameter int ADDR_W = `FCI_ADDR_W,
	parameter int DATA_W = `FCI_DATA_W,
	parameter int DEPTH = `FCI_DEPTH
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_reset_n,
	output logic flash_byte_n,
	output logic [ADDR_W-1:0] flash_addr,
	input wire logic [DATA_W-1:0] flash_dq_in,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_lo,
	output logic flash_dq_oe_hi,
	input wire logic operation_done_pin
);
	import fci_pkg::*;
	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [7:0] RST_LD = 8'(`FCI_CYC(`FCI_T_RST_NS) - 1);
	localparam logic [7:0] RST_REC_LD = 8'(`FCI_CYC(`FCI_T_RST_RECOV_NS) - 1);
	localparam logic [7:0] BUSY_LD = 8'(`FCI_CYC(`FCI_T_BUSY_NS) - 1);
	localparam logic [7:0] TBL_END = 8'(`FCI_OFF_TABLE + `FCI_TABLE_STRIDE * DEPTH);
	localparam logic [3:0] DEPTH_L = 4'(DEPTH);

	// sequence table: one flash write per entry
	logic [ADDR_W-1:0] tbl_addr [DEPTH];
	logic [DATA_W-1:0] tbl_data [DEPTH];
	// control fields
	logic wait_en_reg, byte_mode_reg, read_op_reg, done_ok_reg;
	fci_wait_e method_reg;
	logic [3:0] len_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [31:0] prdata_reg;
	fci_seq_e state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [IW-1:0] idx_reg, idx_next;
	logic flash_rst_n_reg;
	logic cyc_done, watch_done, need_read;
	logic [DATA_W-1:0] cyc_rdata;

	// apb decode
	wire acc = psel && penable;
	wire setup = psel && !penable;
	wire wr = acc && pwrite;
	wire idle = (state_reg == ST_IDLE);
	wire hit_ctrl = (paddr == `FCI_OFF_CTRL);
	wire hit_stat = (paddr == `FCI_OFF_STATUS);
	wire hit_rdat = (paddr == `FCI_OFF_RDATA);
	wire hit_tbl = (paddr >= `FCI_OFF_TABLE) && (paddr < TBL_END) && (paddr[1:0] == 2'b00);
	wire [7:0] tbl_off = paddr - `FCI_OFF_TABLE;
	wire [IW-1:0] tbl_idx = IW'(tbl_off[7:3]);
	wire tbl_hi = tbl_off[2];
	wire mapped = hit_ctrl || hit_stat || hit_rdat || hit_tbl;
	// start orders are taken only while the engine rests
	wire start_req = wr && hit_ctrl && idle && pwdata[`FCI_CTRL_START];
	wire [3:0] wlen = pwdata[`FCI_CTRL_LEN+3:`FCI_CTRL_LEN];
	wire [3:0] len_clip = (wlen > DEPTH_L) ? DEPTH_L : wlen;
	wire go = start_req && (pwdata[`FCI_CTRL_READ] || len_clip != 4'h0);
	// reset order also aborts a wait in ST_SETTLE or ST_POLL, but is ignored during a poll read in ST_POLL_CYC
	wire rst_req = wr && hit_ctrl && pwdata[`FCI_CTRL_HWRST] &&
		(idle || state_reg == ST_SETTLE || state_reg == ST_POLL);
	wire [IW-1:0] last_idx = IW'(len_reg - 4'h1);
	wire last_entry = ({{(4-IW){1'b0}}, idx_reg} + 4'h1) >= len_reg;
	wire polling = (state_reg == ST_POLL) || (state_reg == ST_POLL_CYC);
	wire [IW-1:0] cyc_idx = polling ? last_idx : idx_reg;
	wire cyc_start = (state_reg == ST_ISSUE) || (state_reg == ST_POLL && need_read);
	wire cyc_write = (state_reg == ST_ISSUE) && !read_op_reg;
	wire cnt_zero = (cnt_reg == 8'h00);

	// read mux, sampled in the setup phase
	wire [31:0] tbl_word = tbl_hi ? {{(32-DATA_W){1'b0}}, tbl_data[tbl_idx]} :
		{{(32-ADDR_W){1'b0}}, tbl_addr[tbl_idx]};
	wire [31:0] ctrl_word = {20'h00000, len_reg, 1'b0, read_op_reg, 1'b0, byte_mode_reg,
		method_reg, wait_en_reg, 1'b0};
	wire [31:0] stat_word = {28'h0000000, !flash_rst_n_reg, done_ok_reg,
		operation_done_pin, !idle};
	wire [31:0] rd_word = hit_ctrl ? ctrl_word : hit_stat ? stat_word :
		hit_rdat ? {{(32-DATA_W){1'b0}}, rdata_reg} : hit_tbl ? tbl_word : 32'h00000000;
	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;

	// sequence engine
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_zero ? 8'h00 : cnt_reg - 8'h01;
		idx_next = idx_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				idx_next = '0;
				if (rst_req)
				begin
					state_next = ST_RST;
					cnt_next = RST_LD;
				end
				else if (go)
					state_next = ST_ISSUE;
			end
			ST_RST:
			begin
				if (cnt_zero)
				begin
					state_next = ST_RST_REC;
					cnt_next = RST_REC_LD;
				end
			end
			ST_RST_REC:
			begin
				if (cnt_zero)
					state_next = ST_IDLE;
			end
			ST_ISSUE:
				state_next = ST_CYCLE;
			ST_CYCLE:
			begin
				if (cyc_done)
				begin
					if (read_op_reg)
						state_next = ST_IDLE;
					else if (!last_entry)
					begin
						idx_next = idx_reg + IW'(1);
						state_next = ST_ISSUE;
					end
					else if (wait_en_reg)
					begin
						state_next = ST_SETTLE;
						cnt_next = BUSY_LD;
					end
					else
						state_next = ST_IDLE;
				end
			end
			ST_SETTLE:
			begin
				if (rst_req)
				begin
					state_next = ST_RST;
					cnt_next = RST_LD;
				end
				else if (cnt_zero)
					state_next = ST_POLL;
			end
			ST_POLL:
			begin
				if (rst_req)
				begin
					state_next = ST_RST;
					cnt_next = RST_LD;
				end
				else if (need_read)
					state_next = ST_POLL_CYC;
				else if (watch_done)
					state_next = ST_IDLE;
			end
			ST_POLL_CYC:
			begin
				if (cyc_done)
					state_next = watch_done ? ST_IDLE : ST_POLL;
			end
		endcase
	end

	// engine registers
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 8'h00;
			idx_reg <= '0;
			flash_rst_n_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			flash_rst_n_reg <= (state_next != ST_RST);
		end
	end

	// completion flag: cleared by a new start, set when an order other than a reset finishes
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			done_ok_reg <= 1'b0;
		else if (!idle && state_next == ST_IDLE && state_reg != ST_RST_REC)
			done_ok_reg <= 1'b1;
		else if (start_req)
			done_ok_reg <= 1'b0;
	end

	// control register and read data
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			{len_reg, read_op_reg, byte_mode_reg, wait_en_reg} <= 7'h00;
			method_reg <= WAIT_PIN;
			rdata_reg <= '0;
			prdata_reg <= `FCI_CTRL_RST_VAL;
		end
		else
		begin
			if (wr && hit_ctrl && idle)
			begin
				wait_en_reg <= pwdata[`FCI_CTRL_WAIT];
				method_reg <= fci_wait_e'(pwdata[`FCI_CTRL_METH+1:`FCI_CTRL_METH]);
				byte_mode_reg <= pwdata[`FCI_CTRL_BYTE];
				read_op_reg <= pwdata[`FCI_CTRL_READ];
				len_reg <= len_clip;
			end
			if (state_reg == ST_CYCLE && cyc_done && read_op_reg)
				rdata_reg <= cyc_rdata;
			if (setup)
				prdata_reg <= rd_word;
		end
	end

	// table entries, one generate slice each; frozen while an order runs
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_tbl
			wire sel = wr && hit_tbl && idle && (tbl_idx == IW'(gi));
			always_ff @(posedge clk)
			begin
				if (!reset_n)
				begin
					tbl_addr[gi] <= '0;
					tbl_data[gi] <= '0;
				end
				else if (sel && !tbl_hi)
					tbl_addr[gi] <= pwdata[ADDR_W-1:0];
				else if (sel && tbl_hi)
					tbl_data[gi] <= pwdata[DATA_W-1:0];
			end
		end
	endgenerate

	fci_bus_cycle #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W)
	) u_cycle (
		.clk(clk),
		.reset_n(reset_n),
		.start(cyc_start),
		.write(cyc_write),
		.byte_mode(byte_mode_reg),
		.addr(tbl_addr[cyc_idx]),
		.wdata(tbl_data[cyc_idx]),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n),
		.flash_addr(flash_addr),
		.flash_dq_in(flash_dq_in),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe_lo(flash_dq_oe_lo),
		.flash_dq_oe_hi(flash_dq_oe_hi)
	);

	fci_done_watch #(
		.DATA_W(DATA_W)
	) u_watch (
		.clk(clk),
		.reset_n(reset_n),
		.method(method_reg),
		.clear(state_reg == ST_SETTLE),
		.sample(state_reg == ST_POLL_CYC && cyc_done),
		.rdata(cyc_rdata),
		.expect_bit(tbl_data[last_idx][`FCI_POLL_BIT]),
		.ready_pin(operation_done_pin),
		.need_read(need_read),
		.done(watch_done)
	);

	// byte pin low selects eight-bit configuration
	assign flash_byte_n = !byte_mode_reg;
	assign flash_reset_n = flash_rst_n_reg;
endmodule

// >>> core/fci_defs.svh
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH
// clock period and pin timing figures in ns
`define FCI_CLK_NS 10
`define FCI_T_SETUP_NS 20
`define FCI_T_STROBE_NS 100
`define FCI_T_RECOV_NS 30
`define FCI_T_RST_NS 500
`define FCI_T_RST_RECOV_NS 200
`define FCI_T_BUSY_NS 100
// least times round up to whole cycles
`define FCI_CYC(ns) (((ns) + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
// register byte offsets
`define FCI_OFF_CTRL 8'h00
`define FCI_OFF_STATUS 8'h04
`define FCI_OFF_RDATA 8'h08
`define FCI_OFF_TABLE 8'h40
`define FCI_TABLE_STRIDE 8
`define FCI_CTRL_RST_VAL 32'h00000000
// control register fields
`define FCI_CTRL_START 0
`define FCI_CTRL_WAIT 1
`define FCI_CTRL_METH 2
`define FCI_CTRL_BYTE 4
`define FCI_CTRL_HWRST 5
`define FCI_CTRL_READ 6
`define FCI_CTRL_LEN 8
// status register fields
`define FCI_STAT_BUSY 0
`define FCI_STAT_PIN 1
`define FCI_STAT_DONE 2
`define FCI_STAT_INRST 3
// status bits inside a word read from the flash
`define FCI_POLL_BIT 7
`define FCI_TOGGLE_BIT 6
// bus widths and table depth
`define FCI_ADDR_W 20
`define FCI_DATA_W 16
`define FCI_DEPTH 8
`endif

// >>> core/fci_pkg.sv
package fci_pkg;
	typedef enum logic [1:0] {
		WAIT_PIN = 2'h0,
		WAIT_POLL = 2'h1,
		WAIT_TOGGLE = 2'h2
	} fci_wait_e;
	typedef enum logic [3:0] {
		CYC_IDLE = 4'h1,
		CYC_SETUP = 4'h2,
		CYC_STROBE = 4'h4,
		CYC_RECOV = 4'h8
	} fci_cyc_e;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_RST = 8'h02,
		ST_RST_REC = 8'h04,
		ST_ISSUE = 8'h08,
		ST_CYCLE = 8'h10,
		ST_SETTLE = 8'h20,
		ST_POLL = 8'h40,
		ST_POLL_CYC = 8'h80
	} fci_seq_e;
endpackage

// >>> core/fci_bus_cycle.sv
`timescale 1ns/1ns
`include "fci_defs.svh"
// one asynchronous read or write cycle on the flash pins
module fci_bus_cycle #(
	parameter int ADDR_W = `FCI_ADDR_W,
	parameter int DATA_W = `FCI_DATA_W
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic write,
	input wire logic byte_mode,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic done,
	output logic [DATA_W-1:0] rdata,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic [ADDR_W-1:0] flash_addr,
	input wire logic [DATA_W-1:0] flash_dq_in,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_lo,
	output logic flash_dq_oe_hi
);
	import fci_pkg::*;
	localparam logic [7:0] SETUP_LD = 8'(`FCI_CYC(`FCI_T_SETUP_NS) - 1);
	localparam logic [7:0] STROBE_LD = 8'(`FCI_CYC(`FCI_T_STROBE_NS) - 1);
	localparam logic [7:0] RECOV_LD = 8'(`FCI_CYC(`FCI_T_RECOV_NS) - 1);
	fci_cyc_e state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic write_reg, byte_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg, rdata_reg;
	logic ce_n_reg, we_n_reg, oe_n_reg, oe_lo_reg, oe_hi_reg;
	wire cnt_zero = (cnt_reg == 8'h00);
	// a starting cycle takes the new request, not the flags of the one just finished
	wire write_now = (state_reg == CYC_IDLE) ? write : write_reg;
	wire byte_now = (state_reg == CYC_IDLE) ? byte_mode : byte_reg;
	wire drive_next = write_now && (state_next != CYC_IDLE);
	// phase sequencing: setup, strobe, recovery
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_zero ? 8'h00 : cnt_reg - 8'h01;
		unique case (state_reg)
			CYC_IDLE:
			begin
				if (start)
				begin
					state_next = CYC_SETUP;
					cnt_next = SETUP_LD;
				end
			end
			CYC_SETUP:
			begin
				if (cnt_zero)
				begin
					state_next = CYC_STROBE;
					cnt_next = STROBE_LD;
				end
			end
			CYC_STROBE:
			begin
				if (cnt_zero)
				begin
					state_next = CYC_RECOV;
					cnt_next = RECOV_LD;
				end
			end
			CYC_RECOV:
			begin
				if (cnt_zero)
					state_next = CYC_IDLE;
			end
		endcase
	end
	assign done = (state_reg == CYC_RECOV) && cnt_zero;
	// request latched at start, pins registered from the next phase
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_reg <= CYC_IDLE;
			cnt_reg <= 8'h00;
			write_reg <= 1'b0;
			byte_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
			ce_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			oe_lo_reg <= 1'b0;
			oe_hi_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (start && state_reg == CYC_IDLE)
			begin
				write_reg <= write;
				byte_reg <= byte_mode;
				addr_reg <= addr;
				wdata_reg <= byte_mode ? {{(DATA_W-8){1'b0}}, wdata[7:0]} : wdata;
			end
			if (state_reg == CYC_STROBE && cnt_zero && !write_reg)
				rdata_reg <= byte_reg ? {{(DATA_W-8){1'b0}}, flash_dq_in[7:0]} : flash_dq_in;
			ce_n_reg <= (state_next == CYC_IDLE);
			we_n_reg <= !(state_next == CYC_STROBE && write_reg);
			oe_n_reg <= !(state_next == CYC_STROBE && !write_reg);
			// data driven only on write cycles, never while reading
			oe_lo_reg <= drive_next;
			oe_hi_reg <= drive_next && !byte_now;
		end
	end
	assign rdata = rdata_reg;
	assign flash_ce_n = ce_n_reg;
	assign flash_we_n = we_n_reg;
	assign flash_oe_n = oe_n_reg;
	assign flash_addr = addr_reg;
	assign flash_dq_out = wdata_reg;
	assign flash_dq_oe_lo = oe_lo_reg;
	assign flash_dq_oe_hi = oe_hi_reg;
endmodule

// >>> core/fci_done_watch.sv
`timescale 1ns/1ns
`include "fci_defs.svh"
// decides when an embedded operation has finished
module fci_done_watch #(
	parameter int DATA_W = `FCI_DATA_W
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire fci_pkg::fci_wait_e method,
	input wire logic clear,
	input wire logic sample,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic expect_bit,
	input wire logic ready_pin,
	output logic need_read,
	output logic done
);
	import fci_pkg::*;
	logic prev_toggle_reg;
	logic have_prev_reg;
	// polling bit shows true data once finished; toggle bit stops toggling
	wire poll_hit = sample && (rdata[`FCI_POLL_BIT] == expect_bit);
	wire tog_hit = sample && have_prev_reg && (rdata[`FCI_TOGGLE_BIT] == prev_toggle_reg);
	assign need_read = (method == WAIT_POLL) || (method == WAIT_TOGGLE);
	assign done = (method == WAIT_POLL) ? poll_hit :
		(method == WAIT_TOGGLE) ? tog_hit : ready_pin;
	// first toggle read only primes the comparison
	always_ff @(posedge clk)
	begin
		if (!reset_n || clear)
		begin
			prev_toggle_reg <= 1'b0;
			have_prev_reg <= 1'b0;
		end
		else if (sample)
		begin
			prev_toggle_reg <= rdata[`FCI_TOGGLE_BIT];
			have_prev_reg <= 1'b1;
		end
	end
endmodule

// >>> testbench/fci_ctrl_assertions.sv
`timescale 1ns/1ns
module fci_ctrl_assertions (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic flash_reset_n,
	input wire logic flash_byte_n,
	input wire logic flash_dq_oe_lo,
	input wire logic flash_dq_oe_hi
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// data drive and output enable never overlap, so no contention
	property p_no_fight; flash_dq_oe_lo |-> flash_oe_n; endproperty
	a_no_fight: assert property (p_no_fight) else $error("data driven with output on");
	property p_byte_hi; !flash_byte_n |-> !flash_dq_oe_hi; endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("upper lines driven in byte mode");
	property p_wr_data; !flash_we_n |-> flash_dq_oe_lo && flash_oe_n; endproperty
	a_wr_data: assert property (p_wr_data) else $error("write strobe without data");
	property p_we_len; $fell(flash_we_n) |-> ##9 !flash_we_n ##1 flash_we_n; endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe width wrong");
	property p_setup; $fell(flash_we_n) |-> !$past(flash_ce_n, 2) && $past(flash_ce_n, 3);
	endproperty
	a_setup: assert property (p_setup) else $error("chip select setup wrong");
	property p_recov; $rose(flash_we_n) |-> !flash_ce_n [*3] ##1 flash_ce_n; endproperty
	a_recov: assert property (p_recov) else $error("write recovery wrong");
	property p_rd_len; $fell(flash_oe_n) |-> ##9 !flash_oe_n ##1 flash_oe_n; endproperty
	a_rd_len: assert property (p_rd_len) else $error("read strobe width wrong");
	// a read cycle keeps the data lines released through its whole setup
	property p_rd_quiet;
		$fell(flash_oe_n) |-> !$past(flash_dq_oe_lo) && !$past(flash_dq_oe_lo, 2);
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("data driven in read setup");
	property p_rst_len;
		$fell(flash_reset_n) |-> !flash_reset_n [*8] ##42 !flash_reset_n ##1 flash_reset_n;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse width wrong");
	property p_ready; psel && penable |-> pready && (pslverr == (paddr == 8'h0C)); endproperty
	a_ready: assert property (p_ready) else $error("bus answer wrong");
	c_write: cover property ($rose(flash_we_n));
	c_read: cover property ($rose(flash_oe_n));
	c_reset: cover property ($fell(flash_reset_n));
endmodule
bind fci_ctrl fci_ctrl_assertions u_fci_ctrl_assertions (.clk, .reset_n, .psel, .penable,
	.paddr, .pready, .pslverr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n,
	.flash_byte_n, .flash_dq_oe_lo, .flash_dq_oe_hi);

// >>> testbench/fci_flash_model.sv
`timescale 1ns/1ns
module fci_flash_model #(
	parameter logic [15:0] PROG_CODE = 16'h00A5,
	parameter logic [15:0] ERASE_CODE = 16'h0033
)
(
	input wire logic clk,
	input wire logic slow,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic flash_reset_n,
	input wire logic flash_byte_n,
	input wire logic [19:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe_hi,
	input wire logic unprot,
	input wire logic supply_low,
	output logic [15:0] flash_dq_in,
	output logic operation_done_pin
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] pdata, word = 16'h0000, last = 16'h0000;
	logic [19:0] ptgt;
	logic armed = 1'b0, ers = 1'b0, tog = 1'b0, we_q = 1'b1, oe_q = 1'b1;
	int busy = 0;
	int still = 0;
	logic [19:0] addr_q = 20'h00000;
	// held addresses send the array to sleep; a read strobe wakes it
	wire asleep = (still >= 200);
	wire drv = !flash_ce_n && !flash_oe_n && flash_reset_n;
	wire [15:0] stat = {8'h00, ers ? 1'b0 : ~pdata[7], tog, 6'h00};
	function automatic logic [15:0] rd(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	// released lines show the inverse of their last value, never a kind constant
	assign flash_dq_in = !drv ? ~last : (busy != 0) ? stat :
		flash_byte_n ? word : {~last[15:8], word[7:0]};
	assign operation_done_pin = (busy == 0);
	// commands decoded at the write strobe's rising edge; the work ends after busy
	always @(posedge clk)
	begin
		we_q <= flash_we_n;
		oe_q <= flash_oe_n;
		if (drv)
			last <= flash_dq_in;
		if (flash_oe_n && !oe_q && busy != 0)
			tog <= ~tog;
		if (!flash_reset_n)
		begin
			armed <= 1'b0;
			busy <= 0;
		end
		else if (busy == 1)
		begin
			busy <= 0;
			if (ers)
				mem.delete();
			else if (ptgt[19:16] != 4'hF || unprot)
				mem[ptgt] = rd(ptgt) & pdata;
		end
		else if (busy > 1)
			busy <= busy - 1;
		else if (flash_we_n && !we_q && !flash_ce_n && !supply_low)
		begin
			if (armed)
			begin
				armed <= 1'b0;
				ers <= 1'b0;
				ptgt <= flash_addr;
				pdata <= {flash_dq_oe_hi ? flash_dq_out[15:8] : 8'hFF, flash_dq_out[7:0]};
				busy <= slow ? 400 : 30;
			end
			else if (flash_dq_out == PROG_CODE)
				armed <= 1'b1;
			else if (flash_dq_out == ERASE_CODE)
			begin
				ers <= 1'b1;
				busy <= slow ? 400 : 30;
			end
		end
		addr_q <= flash_addr;
		still <= (flash_addr != addr_q) ? 0 : (still < 1000) ? still + 1 : still;
		if (!asleep || !flash_oe_n)
			word <= rd(flash_addr);
	end
endmodule

// >>> testbench/test_fci_ctrl.sv
`timescale 1ns/1ns
module test_fci_ctrl;
	import fci_pkg::*;
	localparam logic [15:0] PROG = 16'h00A5;
	localparam logic [15:0] ERASE = 16'h0033;
	typedef struct {logic [31:0] v; logic [31:0] m; logic e;} fci_exp_s;
	logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
	logic unprot = 1'b0, supply_low = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_val;
	logic pready, pslverr, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_byte_n;
	logic flash_dq_oe_lo, flash_dq_oe_hi, operation_done_pin;
	logic [19:0] flash_addr, a;
	logic [15:0] flash_dq_in, flash_dq_out, d, d2;
	int n_errors = 0, samples_checked = 0;
	fci_exp_s q[$];
	always #5 clk = ~clk;
	fci_ctrl u_fci_ctrl (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n,
		.flash_byte_n, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe_lo,
		.flash_dq_oe_hi, .operation_done_pin);
	fci_flash_model #(.PROG_CODE(PROG), .ERASE_CODE(ERASE)) u_fci_flash_model (.clk, .slow,
		.flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n, .flash_byte_n, .flash_addr,
		.flash_dq_out, .flash_dq_oe_hi, .unprot, .supply_low, .flash_dq_in, .operation_done_pin);
	task end_sim;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// oldest note is compared against each completed access
	always @(posedge clk)
		if (psel && penable && pready)
		begin
			fci_exp_s x;
			x = q.pop_front();
			samples_checked++;
			if (((prdata & x.m) !== (x.v & x.m)) || (pslverr !== x.e))
			begin
				n_errors++;
				$display("unexpected at %0t: addr %h read %h", $time, paddr, prdata);
			end
		end
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] dt, input logic [31:0] ev,
		input logic [31:0] mk, input logic er);
		int k;
		q.push_back('{ev, mk, er});
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		rd_val = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			n_errors++;
			$display("unexpected at %0t: bus wait timed out", $time);
			end_sim();
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		apb(1'b1, ad, dt, 32'h0, 32'h0, 1'b0);
	endtask
	// poll the busy or pin bit under a bound, then after a busy poll check the final status word
	task idle(input int bitn, input logic [31:0] st);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, 8'h04, 32'h0, 32'h0, 32'h0, 1'b0);
			k++;
		end
		while (rd_val[bitn] !== 1'b0 && k < 400);
		if (rd_val[bitn] !== 1'b0)
		begin
			n_errors++;
			$display("unexpected at %0t: status wait timed out", $time);
			end_sim();
		end
		if (bitn == 0)
			apb(1'b0, 8'h04, 32'h0, st, 32'hFFFFFFFF, 1'b0);
	endtask
	task seq(input logic [15:0] code, input logic [19:0] ad, input logic [15:0] dt,
		input logic [3:0] len, input logic [2:0] meth);
		logic [19:0] ta[4];
		logic [15:0] td[4];
		ta = '{20'h00555, 20'h002AA, 20'h00555, ad};
		td = '{16'h00AA, 16'h0055, code, dt};
		for (int i = 0; i < len; i++)
		begin
			wr(8'(8'h40 + 8 * i), {12'h0, ta[i + 4 - len]});
			wr(8'(8'h44 + 8 * i), {16'h0, td[i + 4 - len]});
		end
		wr(8'h00, {20'h0, len, 3'h0, meth, 2'b11});
	endtask
	task rd_op(input logic [19:0] ad, input logic bm, input logic [31:0] ev);
		wr(8'h40, {12'h0, ad});
		wr(8'h00, {25'h0, 1'b1, 1'b0, bm, 4'h1});
		idle(0, 32'h6);
		apb(1'b0, 8'h08, 32'h0, ev, 32'hFFFFFFFF, 1'b0);
	endtask
	initial
	begin
		void'($urandom(32'hAEF8));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, 8'h00, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
		apb(1'b0, 8'h04, 32'h0, 32'h2, 32'hFFFFFFFF, 1'b0);
		apb(1'b0, 8'h0C, 32'h0, 32'h0, 32'h0, 1'b1);
		$display("reset test finished");
		a = {4'h1, 16'($urandom)} & 20'hFFFF8;
		d = 16'($urandom);
		d2 = 16'($urandom);
		seq(PROG, a, d, 4'h4, 3'h0);
		idle(0, 32'h6);
		rd_op(a, 1'b0, {16'h0, d});
		seq(PROG, a + 20'h2, d2, 4'h2, 3'h1);
		idle(0, 32'h6);
		rd_op(a + 20'h2, 1'b0, {16'h0, d2});
		seq(PROG, a, d2, 4'h4, 3'h2);
		idle(0, 32'h6);
		rd_op(a, 1'b0, {16'h0, d & d2});
		rd_op(a, 1'b1, {24'h0, d[7:0] & d2[7:0]});
		seq(PROG, a + 20'h6, d, 4'h4, 3'h4);
		idle(0, 32'h6);
		rd_op(a + 20'h6, 1'b0, {16'h0, 8'hFF, d[7:0]});
		$display("program test finished");
		seq(PROG, 20'hF0010, 16'h0000, 4'h4, 3'h0);
		idle(0, 32'h6);
		rd_op(20'hF0010, 1'b0, 32'hFFFF);
		unprot <= 1'b1;
		seq(PROG, 20'hF0010, 16'h0000, 4'h4, 3'h0);
		idle(0, 32'h6);
		rd_op(20'hF0010, 1'b0, 32'h0);
		unprot <= 1'b0;
		supply_low <= 1'b1;
		seq(PROG, a + 20'h8, 16'h0000, 4'h4, 3'h0);
		idle(0, 32'h6);
		rd_op(a + 20'h8, 1'b0, 32'hFFFF);
		supply_low <= 1'b0;
		$display("protection test finished");
		slow <= 1'b1;
		seq(PROG, a + 20'h4, d, 4'h4, 3'h0);
		idle(1, 32'h0);
		wr(8'h00, 32'h20);
		idle(0, 32'h2);
		rd_op(a + 20'h4, 1'b0, 32'hFFFF);
		slow <= 1'b0;
		$display("reset abort test finished");
		seq(ERASE, 20'h0, 16'h0030, 4'h4, 3'h0);
		idle(0, 32'h6);
		rd_op(a, 1'b0, 32'hFFFF);
		$display("erase test finished");
		end_sim();
	end
endmodule
